//--- rtl/hj_ports_pkg.sv
package hj_ports_pkg;
   // ==================================================================
   // Register offsets
   localparam logic [4:0] OFF_H_DIR      = 5'h00;
   localparam logic [4:0] OFF_H_PINS     = 5'h01;
   localparam logic [4:0] OFF_H_LATCH    = 5'h02;
   localparam logic [4:0] OFF_ANALOG     = 5'h03;
   localparam logic [4:0] OFF_MEMCTL     = 5'h04;
   localparam logic [4:0] OFF_J_PINS     = 5'h05;
   localparam logic [4:0] OFF_J_LATCH    = 5'h06;
   localparam logic [4:0] OFF_J_DIR      = 5'h07;
   localparam logic [4:0] OFF_SP_CTL     = 5'h08;
   localparam logic [4:0] OFF_D_PINS     = 5'h09;
   localparam logic [4:0] OFF_D_LATCH    = 5'h0A;
   localparam logic [4:0] OFF_D_DIR      = 5'h0B;
   localparam logic [4:0] OFF_E_DIR      = 5'h0C;
   localparam logic [4:0] OFF_PFLAGS     = 5'h0D;
   localparam logic [4:0] OFF_PENABLE    = 5'h0E;
   localparam logic [4:0] OFF_PPRIO      = 5'h0F;
   localparam logic [4:0] OFF_SYS_MODE   = 5'h10;
   // ==================================================================
   // Reset values
   localparam logic [7:0] RST_DIR        = 8'hFF;
   localparam logic [7:0] RST_ZERO       = 8'h00;
   localparam logic [7:0] RST_PPRIO      = 8'h7F;
   // ==================================================================
   // Field positions
   localparam int SP_IBF_BIT    = 7;
   localparam int SP_OBF_BIT    = 6;
   localparam int SP_INPUT_OVERFLOW_FLAG_BIT   = 5;
   localparam int SP_MODE_BIT   = 4;
   localparam int MEM_DIS_BIT   = 7;
   localparam int PF_SPIRQ_BIT  = 7;
   localparam int SYS_ONCHIP_BIT = 0;
   localparam logic [7:0] MEMCTL_MASK  = 8'hB3;
   localparam logic [7:0] ANALOG_MASK  = 8'h3F;
   localparam logic [7:0] SPCTL_WMASK  = 8'h30;
   localparam logic [3:0] ANALOG_DIGITAL = 4'hF;
   // Port E strobe positions
   localparam int E_READ_BIT  = 0;
   localparam int E_WRITE_BIT = 1;
   localparam int E_SEL_BIT   = 2;

   typedef struct packed {
      logic [7:0] out_val;
      logic [7:0] out_en;
   } pin_drive_t;

   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // Upper byte select in bit 7, address latch enable in bit 0
   typedef struct packed {
      logic ub_n;
      logic lb_n;
      logic ce_n;
      logic ba0;
      logic wrh_n;
      logic wrl_n;
      logic oe_n;
      logic ale;
   } mem_ctl_t;
endpackage

//--- rtl/hj_ports.sv
`timescale 1ns/1ps
// Overview of operation
// - Direction bit 1 makes the pin an input with driver off.
// - Direction bit 0 drives the pin from its output latch.
// - Latch reads return the latch, writes update it.
// - Port H upper nibble is analog by default; analog config makes it digital.
// - Analog-configured port H upper pins read as zero.
// - Port H lower nibble carries address bits 16-19 with system bus on.
// - Memory control selects port H lower nibble as I/O or bus.
// - Port J is general I/O only when the system bus is disabled.
// - Bus mode port J bits 0-7: ale, oe, wrl, wrh, ba0, ce, lb, ub.
// - Peripheral direction overrides never change stored direction registers.
// - Port J direction resets to all ones, but the system bus, on after reset, drives the pins.
// - Slave mode bit makes port D a slave port, E0-E2 read/write/select.
// - External write captured when select and write first seen low.
// - External read performed when select and read first seen low.
// - Port D has two bytes: the host writes the input byte and reads the output latch.
// - Input-full sets on external write, clears on internal read.
// - Output-full set by internal write, cleared by external read.
// - Overflow sets on write before previous read; software clears it.
// - Slave port works only in internal-memory-only mode.
// - Read strobe active low; low with select means a read.
module hj_ports
   import hj_ports_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Register port
   input  wire logic [4:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Port H pins
   input  wire logic [7:0] port_h_in,
   output logic      [7:0] port_h_out,
   output logic      [7:0] port_h_oe,
   // Port J pins
   input  wire logic [7:0] port_j_in,
   output logic      [7:0] port_j_out,
   output logic      [7:0] port_j_oe,
   // Port D pins
   input  wire logic [7:0] port_d_in,
   output logic      [7:0] port_d_out,
   output logic      [7:0] port_d_oe,
   // Port E strobes, active low
   input  wire logic [2:0] port_e_in,
   // Memory interface sources
   input  wire logic [3:0] bus_addr_high,
   input  wire logic [7:0] bus_ctl
);

   // ==================================================================
   // Registers
   logic [7:0] port_h_direction;
   logic [7:0] port_h_latch;
   logic [7:0] port_j_direction;
   logic [7:0] port_j_latch;
   logic [7:0] port_d_direction;
   logic [7:0] port_d_latch;
   logic [7:0] port_e_direction;
   logic [7:0] analog_config;
   logic [7:0] memory_interface_control;
   logic [7:0] peripheral_enables_one;
   logic [7:0] peripheral_priority_one;
   logic       sys_onchip;
   logic       slave_port_mode_bit;
   logic       input_full_flag;
   logic       output_full_flag;
   logic       input_overflow_flag;
   logic       slave_port_irq_flag;
   logic [7:0] slave_in_byte;
   logic [2:0] strobe_s1;
   logic [2:0] strobe_s2;
   logic       wr_act_q;
   logic       rd_act_q;
   reg_req_t   req;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   function automatic logic hit(input reg_req_t r, input logic [4:0] off);
      hit = r.wr && (r.addr == off);
   endfunction

   // ==================================================================
   // Mode decode
   logic       bus_on;
   logic       h_analog;
   logic       slave_on;
   logic       wr_act;
   logic       rd_act;
   logic       ext_wr;
   logic       ext_rd;
   logic       cpu_rd_d;
   logic       cpu_wr_d;

   assign bus_on   = !memory_interface_control[MEM_DIS_BIT] && !sys_onchip;
   assign h_analog = (analog_config[3:0] != ANALOG_DIGITAL);
   assign slave_on = slave_port_mode_bit && sys_onchip;
   assign wr_act   = !strobe_s2[E_SEL_BIT] && !strobe_s2[E_WRITE_BIT];
   assign rd_act   = !strobe_s2[E_SEL_BIT] && !strobe_s2[E_READ_BIT];
   assign ext_wr   = slave_on && wr_act && !wr_act_q;
   assign ext_rd   = slave_on && rd_act && !rd_act_q;
   assign cpu_rd_d = req.rd && (req.addr == OFF_D_PINS);
   assign cpu_wr_d = hit(req, OFF_D_PINS) || hit(req, OFF_D_LATCH);

   // ==================================================================
   // Strobe synchroniser
   // two-stage sync
   always_ff @(posedge clk) begin
      if (reset) begin
         strobe_s1 <= 3'h7;
         strobe_s2 <= 3'h7;
         wr_act_q  <= 1'b0;
         rd_act_q  <= 1'b0;
      end else begin
         strobe_s1 <= port_e_in;
         strobe_s2 <= strobe_s1;
         wr_act_q  <= wr_act;
         rd_act_q  <= rd_act;
      end
   end

   // ==================================================================
   // Direction registers
   // overrides never stored
   always_ff @(posedge clk) begin
      if (reset) begin
         port_h_direction <= RST_DIR;
         port_j_direction <= RST_DIR;
         port_d_direction <= RST_DIR;
         port_e_direction <= RST_DIR;
      end else begin
         if (hit(req, OFF_H_DIR)) port_h_direction <= req.wdata;
         if (hit(req, OFF_J_DIR)) port_j_direction <= req.wdata;
         if (hit(req, OFF_D_DIR)) port_d_direction <= req.wdata;
         if (hit(req, OFF_E_DIR)) port_e_direction <= req.wdata;
      end
   end

   // ==================================================================
   // Output latches
   // pin or latch writes load latch
   always_ff @(posedge clk) begin
      if (reset) begin
         port_h_latch <= RST_ZERO;
         port_j_latch <= RST_ZERO;
      end else begin
         if (hit(req, OFF_H_PINS) || hit(req, OFF_H_LATCH)) port_h_latch <= req.wdata;
         if (hit(req, OFF_J_PINS) || hit(req, OFF_J_LATCH)) port_j_latch <= req.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         port_d_latch  <= RST_ZERO;
         slave_in_byte <= RST_ZERO;
      end else begin
         if (cpu_wr_d) port_d_latch <= req.wdata;
         if (ext_wr) slave_in_byte <= port_d_in;
      end
   end

   // ==================================================================
   // Configuration registers
   always_ff @(posedge clk) begin
      if (reset) begin
         analog_config            <= RST_ZERO;
         memory_interface_control <= RST_ZERO;
         peripheral_enables_one   <= RST_ZERO;
         peripheral_priority_one  <= RST_PPRIO;
         sys_onchip               <= 1'b0;
         slave_port_mode_bit      <= 1'b0;
      end else begin
         if (hit(req, OFF_ANALOG)) analog_config <= req.wdata & ANALOG_MASK;
         if (hit(req, OFF_MEMCTL)) memory_interface_control <= req.wdata & MEMCTL_MASK;
         if (hit(req, OFF_PENABLE)) peripheral_enables_one <= req.wdata;
         if (hit(req, OFF_PPRIO)) peripheral_priority_one <= req.wdata;
         if (hit(req, OFF_SYS_MODE)) sys_onchip <= req.wdata[SYS_ONCHIP_BIT];
         if (hit(req, OFF_SP_CTL)) slave_port_mode_bit <= req.wdata[SP_MODE_BIT];
      end
   end

   // ==================================================================
   // Slave port flags, set wins over clear
   // input full
   always_ff @(posedge clk) begin
      if (reset) input_full_flag <= 1'b0;
      else if (ext_wr) input_full_flag <= 1'b1;
      else if (cpu_rd_d) input_full_flag <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (reset) output_full_flag <= 1'b0;
      else if (slave_on && cpu_wr_d) output_full_flag <= 1'b1;
      else if (ext_rd) output_full_flag <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         input_overflow_flag <= 1'b0;
      end else if (ext_wr && input_full_flag && !cpu_rd_d) begin
         input_overflow_flag <= 1'b1;
      end else if (hit(req, OFF_SP_CTL) && !req.wdata[SP_INPUT_OVERFLOW_FLAG_BIT]) begin
         input_overflow_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) slave_port_irq_flag <= 1'b0;
      else if (ext_wr || ext_rd) slave_port_irq_flag <= 1'b1;
      else if (hit(req, OFF_PFLAGS) && !req.wdata[PF_SPIRQ_BIT])
         slave_port_irq_flag <= 1'b0;
   end

   // ==================================================================
   // Pin drivers
   logic [7:0] next_h_out;
   logic [7:0] next_h_oe;
   logic [7:0] next_j_out;
   logic [7:0] next_j_oe;
   logic [7:0] next_d_out;
   logic [7:0] next_d_oe;
   mem_ctl_t   mc;

   assign mc = mem_ctl_t'(bus_ctl);

   always_comb begin
      next_h_oe  = ~port_h_direction;
      next_h_out = port_h_latch;
      if (h_analog) next_h_oe[7:4] = 4'h0;
      if (bus_on) begin
         next_h_out[3:0] = bus_addr_high;
         next_h_oe[3:0]  = 4'hF;
      end
      next_j_oe  = ~port_j_direction;
      next_j_out = port_j_latch;
      if (bus_on) begin
         next_j_out = {mc.ub_n, mc.lb_n, mc.ce_n, mc.ba0,
                       mc.wrh_n, mc.wrl_n, mc.oe_n, mc.ale};
         next_j_oe  = 8'hFF;
      end
      next_d_oe  = ~port_d_direction;
      next_d_out = port_d_latch;
      if (slave_on) next_d_oe = rd_act ? 8'hFF : 8'h00;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         port_h_out <= RST_ZERO;
         port_h_oe  <= RST_ZERO;
         port_j_out <= RST_ZERO;
         port_j_oe  <= RST_ZERO;
         port_d_out <= RST_ZERO;
         port_d_oe  <= RST_ZERO;
      end else begin
         port_h_out <= next_h_out;
         port_h_oe  <= next_h_oe;
         port_j_out <= next_j_out;
         port_j_oe  <= next_j_oe;
         port_d_out <= next_d_out;
         port_d_oe  <= next_d_oe;
      end
   end

   // ==================================================================
   // Read path
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = RST_ZERO;
      if (!req.rd) next_rdata = RST_ZERO;
      else if (req.addr == OFF_H_DIR) next_rdata = port_h_direction;
      else if (req.addr == OFF_H_PINS) begin
         next_rdata = port_h_in;
         if (h_analog) next_rdata[7:4] = 4'h0;
      end
      else if (req.addr == OFF_H_LATCH) next_rdata = port_h_latch;
      else if (req.addr == OFF_ANALOG) next_rdata = analog_config;
      else if (req.addr == OFF_MEMCTL) next_rdata = memory_interface_control;
      else if (req.addr == OFF_J_PINS) next_rdata = port_j_in;
      else if (req.addr == OFF_J_LATCH) next_rdata = port_j_latch;
      else if (req.addr == OFF_J_DIR) next_rdata = port_j_direction;
      else if (req.addr == OFF_SP_CTL)
         next_rdata = {input_full_flag, output_full_flag, input_overflow_flag,
                       slave_port_mode_bit, 4'h0};
      else if (req.addr == OFF_D_PINS) next_rdata = slave_on ? slave_in_byte : port_d_in;
      else if (req.addr == OFF_D_LATCH) next_rdata = port_d_latch;
      else if (req.addr == OFF_D_DIR) next_rdata = port_d_direction;
      else if (req.addr == OFF_E_DIR) next_rdata = port_e_direction;
      else if (req.addr == OFF_PFLAGS) next_rdata = {slave_port_irq_flag, 7'h00};
      else if (req.addr == OFF_PENABLE) next_rdata = peripheral_enables_one;
      else if (req.addr == OFF_PPRIO) next_rdata = peripheral_priority_one;
      else if (req.addr == OFF_SYS_MODE) next_rdata = {7'h00, sys_onchip};
   end

   always_ff @(posedge clk) begin
      if (reset) reg_rdata <= RST_ZERO;
      else reg_rdata <= next_rdata;
   end

   // ==================================================================
   // Checks
   sequence host_write_s;
      slave_on && wr_act && !wr_act_q;
   endsequence

   sequence host_read_s;
      slave_on && rd_act && !rd_act_q;
   endsequence

   j_input_reset_a: assert property (@(posedge clk) disable iff (reset)
      $past(reset) |-> port_j_direction == RST_DIR && port_j_oe == 8'h00)
      else $error("port J not input after reset");
   h_dir_drive_a: assert property (@(posedge clk) disable iff (reset)
      !bus_on && !h_analog |=> port_h_oe == ~$past(port_h_direction))
      else $error("port H enable mismatch");
   h_latch_out_a: assert property (@(posedge clk) disable iff (reset)
      !bus_on |=> port_h_out == $past(port_h_latch))
      else $error("port H output mismatch");
   latch_read_a: assert property (@(posedge clk) disable iff (reset)
      req.rd && req.addr == OFF_H_LATCH |=> reg_rdata == $past(port_h_latch))
      else $error("latch read wrong");
   analog_zero_a: assert property (@(posedge clk) disable iff (reset)
      req.rd && req.addr == OFF_H_PINS && h_analog |=> reg_rdata[7:4] == 4'h0)
      else $error("analog pins not zero");
   bus_addr_a: assert property (@(posedge clk) disable iff (reset)
      bus_on |=> port_h_oe[3:0] == 4'hF && port_h_out[3:0] == $past(bus_addr_high))
      else $error("address bits missing");
   j_bus_a: assert property (@(posedge clk) disable iff (reset)
      bus_on |=> port_j_out == $past(bus_ctl) && port_j_oe == 8'hFF)
      else $error("port J bus order");
   ibf_set_a: assert property (@(posedge clk) disable iff (reset)
      host_write_s |=> input_full_flag && slave_in_byte == $past(port_d_in))
      else $error("input full not set");
   ovf_set_a: assert property (@(posedge clk) disable iff (reset)
      host_write_s ##0 (input_full_flag && !cpu_rd_d) |=> input_overflow_flag)
      else $error("overflow not flagged");
   obf_clr_a: assert property (@(posedge clk) disable iff (reset)
      ext_rd && !(slave_on && cpu_wr_d) |=> !output_full_flag)
      else $error("output full not cleared");
   mode_gate_a: assert property (@(posedge clk) disable iff (reset)
      !sys_onchip |=> $stable(input_full_flag) || !input_full_flag)
      else $error("slave port active off-chip mode");
   j_io_drive_a: assert property (@(posedge clk) disable iff (reset)
      !bus_on |=> port_j_oe == ~$past(port_j_direction) && port_j_out == $past(port_j_latch))
      else $error("port J general io mismatch");
   d_read_drive_a: assert property (@(posedge clk) disable iff (reset)
      host_read_s |=> port_d_oe == 8'hFF && port_d_out == $past(port_d_latch))
      else $error("port D not driven for host read");
   d_plain_io_a: assert property (@(posedge clk) disable iff (reset)
      !slave_on |=> port_d_oe == ~$past(port_d_direction))
      else $error("port D enable mismatch outside slave mode");

endmodule

//--- verif/ext_host.sv
`timescale 1ns/1ps
module ext_host
   import hj_ports_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Strobes and data toward the slave port
   output logic      [2:0] strobe_n,
   output logic      [7:0] data_drv,
   // Port D as seen on the wire
   input  wire logic [7:0] data_wire,
   input  wire logic [7:0] data_oe
);
   // ==================================================================
   // Idle lines
   initial begin
      strobe_n = 3'h7;
      data_drv = 8'h00;
   end
   // ==================================================================
   // Host write, hold cycles chosen by the caller
   // strobes held low then released
   task automatic host_write(input logic [7:0] b, input int hold);
      @(posedge clk);
      strobe_n[E_SEL_BIT]   <= 1'b0;
      strobe_n[E_WRITE_BIT] <= 1'b0;
      data_drv              <= b;
      repeat (hold) @(posedge clk);
      strobe_n <= 3'h7;
      data_drv <= ~b;
      repeat (6) @(posedge clk);
   endtask
   // ==================================================================
   // Host read, bounded wait for the port to drive
   // select and read low
   task automatic host_read(output logic [7:0] b, output logic ok);
      int n;
      ok = 1'b0;
      b  = 8'h00;
      @(posedge clk);
      strobe_n[E_SEL_BIT]  <= 1'b0;
      strobe_n[E_READ_BIT] <= 1'b0;
      for (n = 0; n < 12 && !ok; n++) begin
         @(posedge clk);
         if (data_oe === 8'hFF) begin
            ok = 1'b1;
            b  = data_wire;
         end
      end
      repeat (2) @(posedge clk);
      strobe_n <= 3'h7;
      repeat (6) @(posedge clk);
   endtask
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
   $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_top;
   import hj_ports_pkg::*;
   // ==================================================================
   // Signals
   logic       clk;
   logic       reset;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic [7:0] h_ext, j_ext, h_out, h_oe, j_out, j_oe, d_out, d_oe, d_drv, v;
   logic [2:0] strobe_n;
   logic [3:0] bus_addr_high;
   logic [7:0] bus_ctl;
   logic       ok;
   int         errors;
   int         num_checks;
   localparam logic [4:0] RA [0:11] = '{5'h00, 5'h03, 5'h04, 5'h07, 5'h08, 5'h0B,
                                         5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h1F};
   localparam logic [7:0] RV [0:11] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF,
                                         8'hFF, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h00};
   wire logic [7:0] h_wire = (h_out & h_oe) | (h_ext & ~h_oe);
   wire logic [7:0] j_wire = (j_out & j_oe) | (j_ext & ~j_oe);
   wire logic [7:0] d_wire = (d_out & d_oe) | (d_drv & ~d_oe);
   // ==================================================================
   // Design and far side
   hj_ports dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_h_in(h_wire),
      .port_h_out(h_out), .port_h_oe(h_oe), .port_j_in(j_wire), .port_j_out(j_out),
      .port_j_oe(j_oe), .port_d_in(d_wire), .port_d_out(d_out), .port_d_oe(d_oe),
      .port_e_in(strobe_n), .bus_addr_high(bus_addr_high), .bus_ctl(bus_ctl));
   ext_host host (.clk(clk), .strobe_n(strobe_n), .data_drv(d_drv), .data_wire(d_wire),
      .data_oe(d_oe));
   always #20 clk = ~clk;
   // ==================================================================
   // Register port tasks
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      `CHK($sformatf("reg %h", a), exp, d)
   endtask
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ==================================================================
   // Main sequence
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      h_ext = 8'hF0;
      j_ext = 8'h00;
      bus_addr_high = 4'hA;
      bus_ctl = 8'h96;
      errors = 0;
      num_checks = 0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 12; i++) begin
         rd_chk(RA[i], RV[i]);
      end
      wr(5'h1F, 8'hFF);
      rd_chk(5'h1F, 8'h00);
      $display("test reset values done");
      settle();
      `CHK("h_oe low", 4'hF, h_oe[3:0])
      `CHK("h_out low", 4'hA, h_out[3:0])
      `CHK("j_oe", 8'hFF, j_oe)
      `CHK("j_out", 8'h96, j_out)
      rd(OFF_H_PINS, v);
      `CHK("h analog", 4'h0, v[7:4])
      rd_chk(OFF_J_DIR, 8'hFF);
      @(posedge clk);
      bus_addr_high <= 4'h3;
      bus_ctl <= 8'h69;
      settle();
      `CHK("h_out low", 4'h3, h_out[3:0])
      `CHK("j_out", 8'h69, j_out)
      $display("test system bus done");
      wr(OFF_MEMCTL, 8'h80);
      wr(OFF_ANALOG, 8'h0F);
      wr(OFF_H_LATCH, 8'hC3);
      wr(OFF_H_DIR, 8'h0F);
      @(posedge clk);
      h_ext <= 8'h0A;
      settle();
      `CHK("h_oe", 8'hF0, h_oe)
      `CHK("h_out", 8'hC0, h_out & h_oe)
      rd_chk(OFF_H_PINS, 8'hCA);
      rd_chk(OFF_H_LATCH, 8'hC3);
      wr(OFF_J_PINS, 8'h3C);
      rd_chk(OFF_J_LATCH, 8'h3C);
      wr(OFF_J_DIR, 8'h00);
      settle();
      `CHK("j_oe", 8'hFF, j_oe)
      `CHK("j_out", 8'h3C, j_out)
      wr(OFF_J_DIR, 8'hFF);
      settle();
      `CHK("j_oe", 8'h00, j_oe)
      $display("test general io done");
      wr(OFF_E_DIR, 8'hFF);
      wr(OFF_SP_CTL, 8'h10);
      host.host_write(8'h11, 4);
      rd_chk(OFF_SP_CTL, 8'h10);
      wr(OFF_SYS_MODE, 8'h01);
      host.host_write(8'h3C, 4);
      rd_chk(OFF_SP_CTL, 8'h90);
      rd_chk(OFF_PFLAGS, 8'h80);
      rd_chk(OFF_D_PINS, 8'h3C);
      rd_chk(OFF_SP_CTL, 8'h10);
      host.host_write(8'h21, 12);
      host.host_write(8'h42, 4);
      rd_chk(OFF_SP_CTL, 8'hB0);
      rd(OFF_D_PINS, v);
      rd_chk(OFF_SP_CTL, 8'h30);
      wr(OFF_SP_CTL, 8'h10);
      rd_chk(OFF_SP_CTL, 8'h10);
      wr(OFF_PFLAGS, 8'h00);
      rd_chk(OFF_PFLAGS, 8'h00);
      wr(OFF_D_LATCH, 8'h5A);
      rd_chk(OFF_SP_CTL, 8'h50);
      host.host_read(v, ok);
      `CHK("host read ok", 1'b1, ok)
      if (ok !== 1'b1) begin
         summarize();
      end
      `CHK("host byte", 8'h5A, v)
      rd_chk(OFF_SP_CTL, 8'h10);
      rd_chk(OFF_PFLAGS, 8'h80);
      $display("test slave port done");
      summarize();
   end
endmodule
